// ==== design/ift_footer.sv ====
// Frame timestamp latch and 32-byte footer appender
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "ift_consts.svh"
module ift_footer import ift_pkg::*; #(
	parameter int PPS_MIN_TICKS = `IFT_PPS_MIN,
	parameter int PPS_MAX_TICKS = `IFT_PPS_MAX
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// Camera frame timing
	input wire logic frame_valid,
	// Own time-code input and pulse per second
	input wire logic ext_tc_clk,
	input wire logic ext_tc_data,
	input wire logic ext_tc_frame,
	input wire logic ext_pps,
	// Time-code and pulse from the leader board
	input wire logic fol_tc_clk,
	input wire logic fol_tc_data,
	input wire logic fol_tc_frame,
	input wire logic fol_pps,
	// Image stream in
	input wire logic in_valid,
	input wire logic [31:0] in_data,
	input wire logic in_last,
	output logic in_ready,
	// DMA stream out
	output logic out_valid,
	output logic [31:0] out_data,
	output logic out_last,
	input wire logic out_ready
);

	localparam logic [31:0] TICK_STEP = 32'(`IFT_OSC_HZ / `IFT_CLK_HZ);
	localparam logic [31:0] PPS_MIN = 32'(PPS_MIN_TICKS);
	localparam logic [31:0] PPS_MAX = 32'(PPS_MAX_TICKS);
	localparam logic [3:0] IDX_IMAGE = 4'h8;

	if (PPS_MIN_TICKS < 1 || PPS_MIN_TICKS >= PPS_MAX_TICKS) begin : g_chk
		$error("ift_footer: pulse window bounds are inconsistent");
	end

	ift_state_struct_type s_r;
	ift_state_struct_type s_nxt;
	logic [1:0] rst_sync_r;
	logic rst_core_n;
	logic [8:0] pins_q;
	logic fv;
	logic tclk;
	logic tdata;
	logic tfrm;
	logic pps;
	logic fv_rise;
	logic pps_rise;
	logic tclk_rise;
	logic tfrm_fall;
	logic err_clr;
	logic ifc_fall;
	logic slot_free;
	logic in_take;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_core_n = rst_sync_r[1];

	// All pins cross into the clock domain before use
	ift_sync #(
		.WIDTH(9)
	) u_sync (
		.clk(clk),
		.rst_n(rst_core_n),
		.d({frame_valid, ext_tc_clk, ext_tc_data, ext_tc_frame, ext_pps,
			fol_tc_clk, fol_tc_data, fol_tc_frame, fol_pps}),
		.q(pins_q)
	);

	// Source select; both sets are synchronised so a switch is glitch free
	always_comb begin
		fv = pins_q[8];
		if (s_r.ctrl[`IFT_CTRL_FOLLOW]) begin
			tclk = pins_q[3];
			tdata = pins_q[2];
			tfrm = pins_q[1];
			pps = pins_q[0];
		end else begin
			tclk = pins_q[7];
			tdata = pins_q[6];
			tfrm = pins_q[5];
			pps = pins_q[4];
		end
	end

	// Edge events and stream handshake terms
	assign fv_rise = fv && !s_r.fv_d;
	assign pps_rise = pps && !s_r.pps_d;
	assign tclk_rise = tclk && !s_r.tclk_d;
	assign tfrm_fall = !tfrm && s_r.tfrm_d;
	assign err_clr = reg_wr && reg_addr == `IFT_A_ERRCLR && reg_wdata[0];
	assign ifc_fall = reg_wr && reg_addr == `IFT_A_CTRL &&
		s_r.ctrl[`IFT_CTRL_IFC_RST] && !reg_wdata[`IFT_CTRL_IFC_RST];
	assign slot_free = !s_r.out_v || out_ready;
	assign in_ready = s_r.fsm == IFT_PASS && slot_free;
	assign in_take = in_valid && in_ready;

	// Next state of the whole block
	always_comb begin
		logic tc_set;
		logic pps_set;
		logic [4:0] ev;
		logic [31:0] fw;
		s_nxt = s_r;
		tc_set = 1'b0;
		pps_set = 1'b0;
		ev = 5'h0;
		fw = 32'h0000_0000;
		s_nxt.fv_d = fv;
		s_nxt.tclk_d = tclk;
		s_nxt.tfrm_d = tfrm;
		s_nxt.pps_d = pps;

		// Tick counter in 40 MHz units, two ticks per clock
		s_nxt.tick = s_r.tick + TICK_STEP;
		if (pps_rise) begin
			s_nxt.total = s_r.tick;
			s_nxt.tick = 32'h0000_0000;
			s_nxt.secs = s_r.secs + 32'h0000_0001;
			s_nxt.pps_ok = s_r.tick >= PPS_MIN && s_r.tick <= PPS_MAX;
			pps_set = !s_nxt.pps_ok;
			ev[`IFT_EV_PPS] = 1'b1;
		end else if (s_r.tick > PPS_MAX) begin
			// Missing pulse; flag once, then stop counting further
			s_nxt.tick = s_r.tick;
			pps_set = s_r.pps_ok;
			s_nxt.pps_ok = 1'b0;
		end

		// Time-code word arrives LSB first while its frame line is high
		if (tclk_rise && tfrm) begin
			s_nxt.tc_sh = {tdata, s_r.tc_sh[31:1]};
			if (s_r.tc_cnt <= 6'(`IFT_TC_BITS)) begin
				s_nxt.tc_cnt = s_r.tc_cnt + 6'h01;
			end
		end
		if (tfrm_fall) begin
			s_nxt.tc_cnt = 6'h00;
			if (s_r.tc_cnt == 6'(`IFT_TC_BITS)) begin
				// Fields already packed sec/min/hour/day/year from LSB
				s_nxt.tc_word = s_r.tc_sh;
				s_nxt.tc_ok = 1'b1;
			end else begin
				s_nxt.tc_ok = 1'b0;
				tc_set = 1'b1;
			end
		end

		// Sticky errors: a new error beats a clear in the same cycle
		s_nxt.tc_err = (s_r.tc_err && !err_clr) || tc_set;
		s_nxt.pps_err = (s_r.pps_err && !err_clr) || pps_set;
		ev[`IFT_EV_TCERR] = tc_set;
		ev[`IFT_EV_PPSERR] = pps_set;

		// Time captured at frame start, emitted later in the footer
		if (fv_rise) begin
			s_nxt.lat_time = s_r.ctrl[`IFT_CTRL_BCD] ?
				s_r.tc_word : s_r.secs;
			s_nxt.lat_tick = s_r.tick;
			s_nxt.lat_stat = {s_r.pps_err, s_r.tc_err, s_r.pps_ok,
				s_r.tc_ok, s_r.ctrl[`IFT_CTRL_BCD] ?
				`IFT_TYPE_BCD : `IFT_TYPE_SECS};
			ev[`IFT_EV_FRAME] = 1'b1;
		end

		// Footer word for the current index
		case (s_r.idx)
			`IFT_W_SIG: fw = `IFT_SIG;
			`IFT_W_FRAME: fw = s_r.frames;
			`IFT_W_TIME: fw = s_r.lat_time;
			`IFT_W_TICK: fw = s_r.lat_tick;
			`IFT_W_TOTAL: fw = s_r.total;
			`IFT_W_STATUS: fw = {24'h00_0000, s_r.lat_stat};
			default: fw = 32'h0000_0000;
		endcase

		// Output slot empties when the sink takes it
		if (out_ready) begin
			s_nxt.out_v = 1'b0;
		end
		case (s_r.fsm)
			IFT_PASS: begin
				// Image words pass unchanged
				if (in_take) begin
					s_nxt.out_v = 1'b1;
					s_nxt.out_d = in_data;
					s_nxt.out_idx = IDX_IMAGE;
					s_nxt.out_l = in_last &&
						!s_r.ctrl[`IFT_CTRL_FOOT_EN];
					if (in_last && s_r.ctrl[`IFT_CTRL_FOOT_EN]) begin
						s_nxt.fsm = IFT_FOOT;
						s_nxt.idx = 3'h0;
					end else if (in_last) begin
						s_nxt.frames = s_r.frames + 32'h0000_0001;
					end
				end
			end
			IFT_FOOT: begin
				// Eight footer words right after the last image word
				if (slot_free) begin
					s_nxt.out_v = 1'b1;
					s_nxt.out_d = fw;
					s_nxt.out_idx = {1'b0, s_r.idx};
					s_nxt.out_l = s_r.idx == `IFT_W_LAST;
					s_nxt.idx = s_r.idx + 3'h1;
					if (s_r.idx == `IFT_W_LAST) begin
						s_nxt.fsm = IFT_PASS;
						s_nxt.frames = s_r.frames + 32'h0000_0001;
						ev[`IFT_EV_FOOT] = 1'b1;
					end
				end
			end
			default: s_nxt.fsm = IFT_PASS;
		endcase

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`IFT_A_CTRL: s_nxt.ctrl = reg_wdata[3:0];
				`IFT_A_SECS: s_nxt.secs = reg_wdata;
				`IFT_A_IRQ_EN: s_nxt.irq_en = reg_wdata[4:0];
				default: s_nxt.ctrl = s_nxt.ctrl;
			endcase
		end
		if (ifc_fall) begin
			s_nxt.frames = 32'h0000_0000;
		end

		// Interrupt status: set beats clear
		s_nxt.irq_st = s_r.irq_st & ~((reg_wr &&
			reg_addr == `IFT_A_IRQ_CLR) ? reg_wdata[4:0] : 5'h00);
		s_nxt.irq_st = s_nxt.irq_st | ev;

		// Read data stand for one cycle only
		s_nxt.rd = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`IFT_A_CTRL: s_nxt.rd = {28'h000_0000, s_r.ctrl};
				`IFT_A_SECS: s_nxt.rd = s_r.secs;
				`IFT_A_TCWORD: s_nxt.rd = s_r.tc_word;
				`IFT_A_TICK: s_nxt.rd = s_r.tick;
				`IFT_A_TOTAL: s_nxt.rd = s_r.total;
				`IFT_A_FRAMES: s_nxt.rd = s_r.frames;
				`IFT_A_STATUS: s_nxt.rd = {28'h000_0000, s_r.pps_err,
					s_r.tc_err, s_r.pps_ok, s_r.tc_ok};
				`IFT_A_IRQ_ST: s_nxt.rd = {27'h000_0000, s_r.irq_st};
				`IFT_A_IRQ_EN: s_nxt.rd = {27'h000_0000, s_r.irq_en};
				default: s_nxt.rd = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from state
	assign out_valid = s_r.out_v;
	assign out_data = s_r.out_d;
	assign out_last = s_r.out_l;
	assign reg_rdata = s_r.rd;
	assign irq = |(s_r.irq_st & s_r.irq_en);

	// Checks on the state the block drives
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_core_n);

	sequence seq_img_end;
		in_take && in_last && s_r.ctrl[`IFT_CTRL_FOOT_EN];
	endsequence
	sequence seq_sig_out;
		s_r.out_v && s_r.out_idx == 4'h0 && s_r.out_d == `IFT_SIG;
	endsequence

	a_footer_follows: assert property (seq_img_end |=> ##[0:40] seq_sig_out)
		else $error("footer signature did not follow image end");
	a_footer_last: assert property (s_r.out_v && s_r.out_idx == 4'h7 |-> s_r.out_l)
		else $error("last footer word lacks last flag");
	a_fv_latch: assert property (fv_rise |=> s_r.lat_tick == $past(s_r.tick))
		else $error("tick not latched at frame start");
	a_pps_total: assert property (pps_rise |=>
		s_r.total == $past(s_r.tick) && s_r.tick == 32'h0000_0000)
		else $error("pulse did not capture and zero tick count");
	a_frame_zero: assert property (ifc_fall |=> s_r.frames == 32'h0000_0000)
		else $error("frame counter not zeroed");
	a_time_word: assert property (s_r.out_v && s_r.out_idx == 4'h2 |->
		s_r.out_d == s_r.lat_time)
		else $error("footer time word mismatch");
	a_type_code: assert property (s_r.out_v && s_r.out_idx == 4'h5 |->
		s_r.out_d[31:8] == 24'h00_0000 &&
		(s_r.out_d[3:0] == `IFT_TYPE_SECS || s_r.out_d[3:0] == `IFT_TYPE_BCD))
		else $error("bad status word");
	a_err_sticky: assert property (s_r.tc_err && !err_clr |=> s_r.tc_err)
		else $error("time-code error flag dropped without clear");

endmodule

// ==== include/ift_consts.svh ====
// Constants for the frame timestamp footer block
`ifndef IFT_CONSTS_SVH
`define IFT_CONSTS_SVH

// Register byte offsets
`define IFT_A_CTRL 8'h00
`define IFT_A_ERRCLR 8'h04
`define IFT_A_SECS 8'h08
`define IFT_A_TCWORD 8'h0C
`define IFT_A_TICK 8'h10
`define IFT_A_TOTAL 8'h14
`define IFT_A_FRAMES 8'h18
`define IFT_A_STATUS 8'h1C
`define IFT_A_IRQ_ST 8'h20
`define IFT_A_IRQ_CLR 8'h24
`define IFT_A_IRQ_EN 8'h28

// Control register bit positions and reset value
`define IFT_CTRL_FOOT_EN 0
`define IFT_CTRL_BCD 1
`define IFT_CTRL_FOLLOW 2
`define IFT_CTRL_IFC_RST 3
`define IFT_CTRL_RST 4'h0

// Footer layout: word index is byte offset / 4
`define IFT_FOOT_WORDS 8
`define IFT_W_SIG 3'h0
`define IFT_W_FRAME 3'h1
`define IFT_W_TIME 3'h2
`define IFT_W_TICK 3'h3
`define IFT_W_TOTAL 3'h4
`define IFT_W_STATUS 3'h5
`define IFT_W_LAST 3'h7
// Signature value is arbitrary
`define IFT_SIG 32'h5A3C_0001

// Status byte fields
`define IFT_TYPE_SECS 4'h3
`define IFT_TYPE_BCD 4'h5

// Interrupt event bits
`define IFT_EV_FRAME 0
`define IFT_EV_FOOT 1
`define IFT_EV_PPS 2
`define IFT_EV_TCERR 3
`define IFT_EV_PPSERR 4
`define IFT_EV_W 5

// Clock rates and time-code word size
`define IFT_OSC_HZ 40_000_000
`define IFT_CLK_HZ 20_000_000
`define IFT_TC_BITS 32
// Acceptable tick total between pulses (40 MHz ticks)
`define IFT_PPS_MIN 39_600_000
`define IFT_PPS_MAX 40_400_000

`endif

// ==== include/ift_pkg.sv ====
// Types shared by the frame timestamp footer block
package ift_pkg;

	// Stream state: pass image data or append footer
	typedef enum logic [0:0] {
		IFT_PASS,
		IFT_FOOT
	} ift_state_type;

	// All state of the footer block
	typedef struct packed {
		ift_state_type fsm;
		logic [2:0] idx;
		logic out_v;
		logic [31:0] out_d;
		logic out_l;
		logic [3:0] out_idx;
		logic [3:0] ctrl;
		logic [31:0] secs;
		logic [31:0] tick;
		logic [31:0] total;
		logic [31:0] frames;
		logic [31:0] lat_time;
		logic [31:0] lat_tick;
		logic [7:0] lat_stat;
		logic [31:0] tc_sh;
		logic [5:0] tc_cnt;
		logic [31:0] tc_word;
		logic tc_ok;
		logic pps_ok;
		logic tc_err;
		logic pps_err;
		logic fv_d;
		logic tclk_d;
		logic tfrm_d;
		logic pps_d;
		logic [4:0] irq_st;
		logic [4:0] irq_en;
		logic [31:0] rd;
	} ift_state_struct_type;

endpackage

// ==== design/ift_sync.sv ====
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module ift_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins and their synchronised copy
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} ift_sync_type;

	ift_sync_type s_r;
	ift_sync_type s_nxt;

	if (WIDTH < 1) begin : g_chk
		$error("ift_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage
	always_comb begin
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;

endmodule

// ==== bench/ift_src.sv ====
// Camera frame timing and time-code source model
`timescale 1ns/1ps
module ift_src (
	// Time-code link
	output logic tc_clk,
	output logic tc_data,
	output logic tc_frame,
	// Pulse per second and camera frame valid
	output logic pps,
	output logic fv
);
	logic pps_run = 1'b0;
	// Link idle; its clock stands still between words
	initial begin
		tc_clk = 1'b0;
		tc_data = 1'b0;
		tc_frame = 1'b0;
		pps = 1'b0;
		fv = 1'b0;
	end
	// Pulse every 150 clocks, inside the accepted tick window
	always begin
		#7000;
		pps = pps_run;
		#500;
		pps = 1'b0;
	end
	// Frame valid; the time latch follows its rising edge
	// Pins move 13 ns off the edge so no step races the sampling flops
	task set_fv(input logic l);
		#13;
		fv = l;
	endtask
	// One word LSB first; a short count breaks the word on purpose
	task send(input logic [31:0] w, input int n);
		#13;
		tc_frame = 1'b1;
		#200;
		for (int i = 0; i < n; i++) begin
			tc_data = w[i];
			#200;
			tc_clk = 1'b1;
			#200;
			tc_clk = 1'b0;
		end
		#200;
		tc_frame = 1'b0;
		// Released line shows the inverse of its last bit
		tc_data = ~tc_data;
		// Idle gap so the word's end clears the synchroniser first
		#200;
	endtask
endmodule

// ==== bench/irig_frame_timestamp_footer_tb.sv ====
// Self-checking bench for the frame timestamp footer block
`timescale 1ns/1ps
`include "ift_consts.svh"
module irig_frame_timestamp_footer_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq, fv, e_clk, e_dat, e_frm, e_pps, f_clk, f_dat, f_frm, f_pps;
	logic in_valid = 1'b0;
	logic [31:0] in_data = 32'h0;
	logic in_last = 1'b0;
	logic in_ready, out_valid, out_last;
	logic [31:0] out_data;
	logic out_ready = 1'b0;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	logic [32:0] q[$];
	logic [31:0] v;
	localparam logic [31:0] W1 = {6'd24, 9'd200, 5'd13, 6'd7, 6'd59};
	localparam logic [31:0] W2 = {6'd3, 9'd1, 5'd0, 6'd0, 6'd1};
	localparam logic [31:0] W3 = {6'd25, 9'd366, 5'd23, 6'd59, 6'd30};

	// 20 MHz clock
	always #25 clk = ~clk;

	// Output stalls one cycle in four; accepted words are queued
	always @(posedge clk) begin
		cyc <= cyc + 1;
		out_ready <= (cyc % 4) != 3;
		if (out_valid === 1'b1 && out_ready)
			q.push_back({out_last, out_data});
	end

	ift_footer #(
		.PPS_MIN_TICKS(200),
		.PPS_MAX_TICKS(400)
	) i_dut (
		.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.frame_valid(fv),
		.ext_tc_clk(e_clk), .ext_tc_data(e_dat),
		.ext_tc_frame(e_frm), .ext_pps(e_pps),
		.fol_tc_clk(f_clk), .fol_tc_data(f_dat),
		.fol_tc_frame(f_frm), .fol_pps(f_pps),
		.in_valid(in_valid), .in_data(in_data), .in_last(in_last),
		.in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
		.out_last(out_last), .out_ready(out_ready)
	);
	// Own source also plays the camera; the leader board has none
	ift_src i_ext (.tc_clk(e_clk), .tc_data(e_dat), .tc_frame(e_frm),
		.pps(e_pps), .fv(fv));
	ift_src i_fol (.tc_clk(f_clk), .tc_data(f_dat), .tc_frame(f_frm),
		.pps(f_pps), .fv());

	// Verdict and end of run
	task test_done;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task timeout;
		num_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		test_done;
	endtask
	// Compare with four-state equality
	task chk(input logic [32:0] g, input logic [32:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task chkr(input logic [31:0] g, input int lo, input int hi);
		chk({32'h0, g >= lo && g <= hi}, 1);
	endtask
	// Register port cycles
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(v, e);
	endtask
	// Image words; each held until in_ready is seen at the edge
	task send_img(input int n);
		int k;
		logic r;
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			in_valid <= 1'b1;
			in_data <= 32'hC0DE_0000 + i;
			in_last <= i == n - 1;
			k = 0;
			do begin
				@(negedge clk);
				r = in_ready;
				@(posedge clk);
				k++;
			end while (r !== 1'b1 && k < 100);
			if (k >= 100)
				timeout;
		end
		in_valid <= 1'b0;
		in_last <= 1'b0;
	endtask
	// One frame; a time-code word arrives while it is under way
	task frame(input logic ft, input logic [7:0] st, input logic [31:0] fr,
		input int lo, input int hi, input logic [31:0] mid);
		int k;
		logic [32:0] w;
		q.delete();
		i_ext.set_fv(1'b1);
		i_ext.send(mid, 32);
		send_img(4);
		i_ext.set_fv(1'b0);
		k = 0;
		while (q.size() < (ft ? 12 : 4) && k < 400) begin
			@(posedge clk);
			k++;
		end
		if (k >= 400)
			timeout;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 4; i++)
			chk(q[i], {!ft && i == 3, 32'hC0DE_0000 + i});
		for (int j = 0; j < 8 && ft; j++) begin
			w = q[4 + j];
			chk(w[32], j == 7);
			case (j)
				0: chk(w[31:0], `IFT_SIG);
				1: chk(w[31:0], fr);
				2: chkr(w[31:0], lo, hi);
				3: chkr(w[31:0], 0, 302);
				4: chkr(w[31:0], 296, 302);
				5: chk(w[31:0], {24'h0, st});
				default: chk(w[31:0], 0);
			endcase
		end
		$display("test frame done");
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		i_ext.pps_run = 1'b1;
		i_fol.pps_run = 1'b1;
		repeat (4) @(posedge clk);
		rdc(`IFT_A_CTRL, 0);
		rdc(8'h30, 0);
		repeat (600) @(posedge clk);
		i_ext.send(W1, 32);
		wr(`IFT_A_ERRCLR, 1);
		rdc(`IFT_A_TCWORD, W1);
		rdc(`IFT_A_STATUS, 3);
		rd(`IFT_A_TOTAL);
		chkr(v, 296, 302);
		rd(`IFT_A_TICK);
		chkr(v, 0, 302);
		i_ext.send(W1, 31);
		rdc(`IFT_A_STATUS, 6);
		i_ext.send(W1, 32);
		rdc(`IFT_A_STATUS, 7);
		wr(`IFT_A_ERRCLR, 1);
		rdc(`IFT_A_STATUS, 3);
		$display("test time code done");
		wr(`IFT_A_IRQ_EN, 2);
		wr(`IFT_A_CTRL, 9);
		wr(`IFT_A_CTRL, 1);
		wr(`IFT_A_SECS, 1000);
		frame(1, 8'h33, 0, 1000, 1001, W3);
		chk(irq, 1);
		wr(`IFT_A_IRQ_CLR, 2);
		@(negedge clk);
		chk(irq, 0);
		wr(`IFT_A_IRQ_EN, 0);
		wr(`IFT_A_CTRL, 3);
		frame(1, 8'h35, 1, W3, W3, W1);
		rd(`IFT_A_IRQ_ST);
		chk({irq, v[`IFT_EV_FOOT]}, 1);
		wr(`IFT_A_CTRL, 7);
		i_fol.send(W2, 32);
		rdc(`IFT_A_TCWORD, W2);
		wr(`IFT_A_CTRL, 4);
		frame(0, 8'h00, 0, 0, 0, W1);
		rdc(`IFT_A_FRAMES, 3);
		wr(`IFT_A_CTRL, 12);
		wr(`IFT_A_CTRL, 4);
		rdc(`IFT_A_FRAMES, 0);
		// Pulses stop: tick runs past the window, pulse error sticks
		i_ext.pps_run = 1'b0;
		i_fol.pps_run = 1'b0;
		repeat (400) @(posedge clk);
		rdc(`IFT_A_STATUS, 9);
		wr(`IFT_A_ERRCLR, 1);
		rdc(`IFT_A_STATUS, 1);
		$display("test counter done");
		test_done;
	end
endmodule
